// *** bench/lane_source.sv ***
// lane source model: one word per cycle on every lane, markers per slot
// assumes interval is held steady outside reset
`timescale 1ns/100ps

module lane_source #(
  parameter int lanes = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [15:0]      interval,
  input  wire logic [lanes-1:0] active,
  input  wire logic [lanes-1:0] skip,
  output logic      [lanes-1:0] word_valid,
  output logic      [lanes-1:0] marker_good
);
  logic [15:0] count;

  // marker every interval plus one words; skipped lanes omit it on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count       <= 16'h0000;
      word_valid  <= '0;
      marker_good <= '0;
    end else begin
      word_valid <= '1;
      if (count == interval) begin
        count       <= 16'h0000;
        marker_good <= active & ~skip;
      end else begin
        count       <= count + 16'h0001;
        marker_good <= '0;
      end
    end
  end
endmodule : lane_source

// *** bench/tb.sv ***
// testbench: apb register checks and lane status scenarios
// assumes lane_source feeds the word and marker pulses
`timescale 1ns/100ps

module tb;
  import rx_align_status_pkg::*;
  logic            pclk = 1'b0, presetn = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic            pready, pslverr, irq, err;
  logic [15:0]     interval = 16'h0007;
  logic [3:0]      word_valid, marker_good, active = 4'h0, skip = 4'h0;
  logic [3:0]      malformed = 4'h0, sync = 4'h0, lock = 4'h0;
  logic [3:0][1:0] lane_id = 8'h1b;
  logic            deskew = 1'b0, afault = 1'b0, ber = 1'b0, rfault = 1'b0;
  logic [3:0]      sp_err, rp_err, wd_err, synced, blk, demux;
  logic [3:0][1:0] map;
  logic            aligned, al_err, mis, pcs, lf, rf, her;
  int              errors = 0, comparisons = 0, cyc_n = 0, mis_n = 0;
  int              t_err = 0, t_mis = 0;

  rx_lane_alignment_status #(.lane_count_param(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .marker_interval_minus_one(interval), .word_valid(word_valid),
    .marker_good(marker_good), .marker_malformed(malformed),
    .word_sync_in(sync), .block_lock_in(lock), .lane_id_in(lane_id),
    .deskew_done(deskew), .align_fault_in(afault),
    .ber_over_limit(ber), .remote_fault_in(rfault),
    .marker_spacing_error(sp_err), .marker_repeat_error(rp_err),
    .marker_word_error(wd_err), .word_synced(synced),
    .block_lock(blk), .lane_map_index(map), .lane_demux_done(demux),
    .aligned(aligned), .aligned_error(al_err), .misaligned(mis),
    .pcs_status(pcs), .local_fault(lf), .remote_fault(rf),
    .high_error_rate(her));

  lane_source #(.lanes(4)) src (
    .pclk(pclk), .presetn(presetn), .interval(interval),
    .active(active), .skip(skip), .word_valid(word_valid),
    .marker_good(marker_good));

  always #50 pclk = ~pclk;

  // ----------------------------------------------------------------
  // monitor: sampled values, so both times carry the same offset
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (mis === 1'b1) begin
      mis_n <= mis_n + 1;
      if (t_mis == 0) t_mis <= cyc_n;
    end
    if (sp_err[1] === 1'b1 && t_err == 0) t_err <= cyc_n;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // apb master: request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready is sampled at the edge itself, before that edge updates it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(err, exp_err);
  endtask : rchk

  initial begin
    #5000000;
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // interval stays at 7 from time zero, set while reset is held
    wt(2);
    chk({aligned, al_err, mis, pcs, lf, rf, her, irq}, 32'h0);
    chk({sp_err, rp_err, wd_err, synced, blk, demux}, 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(irq_mask_offset, 32'h0, 1'b0);
    rchk(irq_stat_offset, 32'h0, 1'b0);
    rchk(8'h14, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    apb(1'b1, irq_mask_offset, 32'h0000_000f);
    rchk(irq_mask_offset, 32'h0000_000f, 1'b0);
    // lane 3 never sends a marker, so no lane is demuxed as pcs lane 0
    @(posedge pclk);
    sync   <= 4'hf;
    lock   <= 4'hf;
    active <= 4'h7;
    deskew <= 1'b1;
    wt(30);
    chk(synced, 4'h7);
    chk(demux, 4'he);
    chk(map[2:0], 6'h1b);
    chk({aligned, lf, pcs}, 3'b010);
    chk(blk, 4'hf);
    @(posedge pclk);
    malformed <= 4'h8;
    @(posedge pclk);
    #1;
    chk(wd_err, 4'h8);
    @(posedge pclk);
    malformed <= 4'h0;
    #1;
    chk(wd_err, 4'h8);
    wt(1);
    chk(wd_err, 4'h0);
    chk(irq, 1'b1);
    rchk(irq_stat_offset, 32'h4, 1'b0);
    apb(1'b1, irq_stat_offset, 32'h4);
    rchk(irq_stat_offset, 32'h0, 1'b0);
    chk(mis_n, 32'h0);
    // all lanes good: aligned, then level inputs and alignment loss
    @(posedge pclk);
    active <= 4'hf;
    wt(30);
    chk({synced, demux}, 8'hff);
    chk({aligned, lf, pcs, sp_err}, 7'b1010000);
    rchk(link_stat_offset, 32'h0000_0f05, 1'b0);
    @(posedge pclk);
    ber    <= 1'b1;
    rfault <= 1'b1;
    wt(2);
    chk({her, pcs, rf}, 3'b101);
    rchk(link_stat_offset, 32'h0000_0f19, 1'b0);
    @(posedge pclk);
    ber    <= 1'b0;
    rfault <= 1'b0;
    lock   <= 4'hb;
    wt(3);
    chk({blk, aligned, al_err, lf, rf, her}, 9'h16c);
    chk(irq, 1'b1);
    @(posedge pclk);
    lock <= 4'hf;
    wt(3);
    chk({aligned, al_err}, 2'b10);
    @(posedge pclk);
    afault <= 1'b1;
    wt(3);
    chk({aligned, al_err}, 2'b11);
    @(posedge pclk);
    afault <= 1'b0;
    apb(1'b1, irq_stat_offset, 32'hf);
    rchk(irq_stat_offset, 32'h0, 1'b0);
    chk(mis_n, 32'h0);
    // lane 1 drops its markers: spacing, repeat and misaligned
    @(posedge pclk);
    skip <= 4'h2;
    wt(12);
    chk(sp_err, 4'h2);
    wt(32);
    chk({rp_err, sp_err}, 8'h22);
    chk(mis_n > 0, 1'b1);
    chk(t_mis - t_err, 32'h8);
    @(posedge pclk);
    skip <= 4'h0;
    wt(24);
    chk({rp_err, sp_err}, 8'h00);
    rchk(irq_stat_offset, 32'h9, 1'b0);
    chk(irq, 1'b1);
    apb(1'b1, irq_mask_offset, 32'h0);
    wt(2);
    chk(irq, 1'b0);
    apb(1'b1, irq_stat_offset, 32'hf);
    rchk(irq_stat_offset, 32'h0, 1'b0);
    stop_test();
  end
endmodule : tb

// *** src/rx_align_status_pkg.sv ***
// shared constants for the receive lane alignment status block
// assumes a single pclk domain and an apb slave with 32-bit data
package rx_align_status_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] link_stat_offset = 8'h00;
  localparam logic [7:0] lane_stat_offset = 8'h04;
  localparam logic [7:0] lane_map_offset  = 8'h08;
  localparam logic [7:0] irq_stat_offset  = 8'h0c;
  localparam logic [7:0] irq_mask_offset  = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int aligned_bit      = 0;
  localparam int aligned_err_bit  = 1;
  localparam int pcs_status_bit   = 2;
  localparam int remote_fault_bit = 3;
  localparam int high_err_bit     = 4;
  localparam int local_fault_bit  = 5;
  localparam int block_lock_pos   = 8;
  localparam int demux_pos        = 0;
  localparam int synced_pos       = 8;
  localparam int spacing_pos      = 16;
  localparam int repeat_pos       = 24;

  // interrupt causes
  localparam int irq_width        = 4;
  localparam int irq_misaligned   = 0;
  localparam int irq_align_lost   = 1;
  localparam int irq_word_err     = 2;
  localparam int irq_repeat_err   = 3;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  repeat_limit    = 3'h4;
  localparam logic [15:0] interval_reset  = 16'h0000;
  localparam logic [irq_width-1:0] irq_mask_reset = 4'h0;

endpackage : rx_align_status_pkg

// *** src/rx_lane_alignment_status.sv ***
// receive pcs lane alignment status flags with apb register view
// assumes the marker/deskew datapath runs on pclk and drives the lane
// event pulses and levels directly, with no synchroniser needed
//
// Overview of operation
// R01: per lane spacing error high while markers arrive off the programmed interval
// R02: per lane repeat error after four consecutive marker errors, held till cleared
// R03: malformed marker word gives a one cycle pulse, back to back allowed
// R04: aligned is a level, one only while all lanes aligned and deskewed
// R05: aligned low means local fault; aligned mirrors management bit 3.50.12
// R06: pcs status is aligned and not high error rate, bit 3.32.12
// R07: per lane block lock level, management bits 3.50.7:0 and 3.51.11:0
// R08: alignment error level on alignment error or loss of achieved alignment
// R09: misaligned pulse only after all lanes saw good markers then a bad one
// R10: misaligned pulse comes one metaframe after the error, back to back allowed; here a second error inside the metaframe is folded in
// R11: remote fault level follows the detected remote fault condition
// R12: per physical lane map index, valid only while its sync bit is one
// R13: per lane demux bit once marker found and lane demultiplexed
// R14: sync bit one only after word boundary sync and a received marker
// R15: interval input is words between markers minus one, changed only in reset
// R16: high error rate level one while measured error rate exceeds threshold
// R17: all outputs registered on pclk and zero while reset is held
// R18: no misaligned pulse while any lane never delivered a correct marker
`timescale 1ns/100ps

module rx_lane_alignment_status
  import rx_align_status_pkg::*;
#(
  parameter int lane_count_param = 4,
  parameter int id_width         = $clog2(lane_count_param)
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic [15:0]                marker_interval_minus_one,
  input  wire logic [lane_count_param-1:0] word_valid,
  input  wire logic [lane_count_param-1:0] marker_good,
  input  wire logic [lane_count_param-1:0] marker_malformed,
  input  wire logic [lane_count_param-1:0] word_sync_in,
  input  wire logic [lane_count_param-1:0] block_lock_in,
  input  wire logic [lane_count_param-1:0][id_width-1:0] lane_id_in,
  input  wire logic                       deskew_done,
  input  wire logic                       align_fault_in,
  input  wire logic                       ber_over_limit,
  input  wire logic                       remote_fault_in,
  output logic [lane_count_param-1:0]     marker_spacing_error,
  output logic [lane_count_param-1:0]     marker_repeat_error,
  output logic [lane_count_param-1:0]     marker_word_error,
  output logic [lane_count_param-1:0]     word_synced,
  output logic [lane_count_param-1:0]     block_lock,
  output logic [lane_count_param-1:0][id_width-1:0] lane_map_index,
  output logic [lane_count_param-1:0]     lane_demux_done,
  output logic                            aligned,
  output logic                            aligned_error,
  output logic                            misaligned,
  output logic                            pcs_status,
  output logic                            local_fault,
  output logic                            remote_fault,
  output logic                            high_error_rate
);

  localparam int nl = lane_count_param;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [nl-1:0][15:0]         word_cnt;
    logic [nl-1:0][2:0]          consec;
    logic [nl-1:0]               got_marker;
    logic [nl-1:0]               seen_ok;
    logic [nl-1:0]               spacing;
    logic [nl-1:0]               repeat_e;
    logic [nl-1:0]               word_e;
    logic [nl-1:0]               synced;
    logic [nl-1:0]               lock;
    logic [nl-1:0][id_width-1:0] map;
    logic [nl-1:0]               demux;
    logic                        aligned;
    logic                        aligned_err;
    logic                        misaligned;
    logic                        mf_pend;
    logic [15:0]                 mf_cnt;
    logic                        status;
    logic                        local_f;
    logic                        remote;
    logic                        hi_ber;
    logic [irq_width-1:0]        irq_stat;
    logic [irq_width-1:0]        irq_mask;
    logic                        irq;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
  } state_t;

  state_t r;
  state_t next_r;

  logic [nl-1:0] mk;
  logic [nl-1:0] slot;
  logic [nl-1:0] bad_space;
  logic [nl-1:0] err_evt;
  logic [nl-1:0] next_synced;
  logic [nl-1:0] next_demux;
  logic          next_aligned;
  logic [irq_width-1:0] events;
  logic          wr_hit;
  logic          rd_phase;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    mk = marker_good | marker_malformed;
    next_synced = '0;
    next_demux = '0;
    for (int l = 0; l < nl; l++) begin
      // a slot is where the next marker is due
      slot[l] = word_valid[l] && r.got_marker[l] &&
                r.word_cnt[l] == marker_interval_minus_one; // R15
      bad_space[l] = r.got_marker[l] && (mk[l] != slot[l]);
      err_evt[l] = bad_space[l] | marker_malformed[l];
      if (!word_sync_in[l]) begin
        next_r.word_cnt[l] = '0;
        next_r.consec[l] = '0;
        next_r.got_marker[l] = 1'b0;
        next_r.spacing[l] = 1'b0;
        next_r.repeat_e[l] = 1'b0;
      end else if (mk[l] || slot[l]) begin
        next_r.word_cnt[l] = '0;
        next_r.got_marker[l] = r.got_marker[l] | marker_good[l];
        next_r.spacing[l] = bad_space[l]; // R01
        if (err_evt[l]) begin
          if (r.consec[l] != repeat_limit)
            next_r.consec[l] = r.consec[l] + 3'h1;
        end else begin
          next_r.consec[l] = '0;
        end
        next_r.repeat_e[l] = next_r.consec[l] == repeat_limit; // R02
      end else if (word_valid[l]) begin
        next_r.word_cnt[l] = r.word_cnt[l] + 16'h0001;
      end
      if (marker_good[l] && !bad_space[l])
        next_r.seen_ok[l] = 1'b1;
      next_r.word_e[l] = marker_malformed[l]; // R03
      next_synced[l] = word_sync_in[l] & next_r.got_marker[l]; // R14
      next_r.lock[l] = block_lock_in[l]; // R07
      // map holds its last value while unsynced, flagged invalid
      if (next_synced[l])
        next_r.map[l] = lane_id_in[l]; // R12
    end
    for (int p = 0; p < nl; p++)
      for (int l = 0; l < nl; l++)
        if (next_synced[l] && lane_id_in[l] == p[id_width-1:0])
          next_demux[p] = 1'b1; // R13
    next_r.synced = next_synced;
    next_r.demux = next_demux;

    next_aligned = deskew_done && (&next_demux) && (&block_lock_in); // R04
    next_r.aligned = next_aligned;
    next_r.local_f = !next_aligned; // R05
    next_r.hi_ber = ber_over_limit; // R16
    next_r.status = next_aligned && !ber_over_limit; // R06
    next_r.remote = remote_fault_in; // R11
    // loss stays flagged until alignment comes back
    if (align_fault_in || (r.aligned && !next_aligned))
      next_r.aligned_err = 1'b1; // R08
    else if (next_aligned)
      next_r.aligned_err = 1'b0;

    // one pending metaframe timer: a second error inside it is folded in
    next_r.misaligned = 1'b0;
    if (r.mf_pend) begin
      if (r.mf_cnt == '0) begin
        next_r.misaligned = 1'b1; // R10
        next_r.mf_pend = 1'b0;
      end else if (word_valid[0]) begin
        next_r.mf_cnt = r.mf_cnt - 16'h0001;
      end
    end
    if ((&r.seen_ok) && (|err_evt) &&
        (!r.mf_pend || r.mf_cnt == '0)) begin // R09 R18
      next_r.mf_pend = 1'b1;
      next_r.mf_cnt = marker_interval_minus_one;
    end

    // sticky interrupt causes, set wins over write-one-to-clear
    events = '0;
    events[irq_misaligned] = next_r.misaligned;
    events[irq_align_lost] = r.aligned && !next_aligned;
    events[irq_word_err] = |marker_malformed;
    events[irq_repeat_err] = |(next_r.repeat_e & ~r.repeat_e);

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    rd_phase = psel && penable && !r.pready;
    wr_hit = psel && penable && r.pready && pwrite && !r.pslverr;
    next_r.pready = rd_phase;
    if (rd_phase) begin
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      if (paddr == link_stat_offset) begin
        next_r.prdata[aligned_bit] = r.aligned;
        next_r.prdata[aligned_err_bit] = r.aligned_err;
        next_r.prdata[pcs_status_bit] = r.status;
        next_r.prdata[remote_fault_bit] = r.remote;
        next_r.prdata[high_err_bit] = r.hi_ber;
        next_r.prdata[local_fault_bit] = r.local_f;
        next_r.prdata[block_lock_pos +: nl] = r.lock;
      end else if (paddr == lane_stat_offset) begin
        next_r.prdata[demux_pos +: nl] = r.demux;
        next_r.prdata[synced_pos +: nl] = r.synced;
        next_r.prdata[spacing_pos +: nl] = r.spacing;
        next_r.prdata[repeat_pos +: nl] = r.repeat_e;
      end else if (paddr == lane_map_offset) begin
        next_r.prdata[nl*id_width-1:0] = r.map;
      end else if (paddr == irq_stat_offset) begin
        next_r.prdata[irq_width-1:0] = r.irq_stat;
      end else if (paddr == irq_mask_offset) begin
        next_r.prdata[irq_width-1:0] = r.irq_mask;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end else if (!psel) begin
      next_r.prdata = '0;
      next_r.pslverr = 1'b0;
    end
    next_r.irq_stat = r.irq_stat;
    if (wr_hit && paddr == irq_stat_offset)
      next_r.irq_stat = r.irq_stat & ~pwdata[irq_width-1:0];
    next_r.irq_stat = next_r.irq_stat | events;
    if (wr_hit && paddr == irq_mask_offset)
      next_r.irq_mask = pwdata[irq_width-1:0];
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0; // R17
      r.irq_mask <= irq_mask_reset;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign marker_spacing_error = r.spacing;
  assign marker_repeat_error  = r.repeat_e;
  assign marker_word_error    = r.word_e;
  assign word_synced          = r.synced;
  assign block_lock           = r.lock;
  assign lane_map_index       = r.map;
  assign lane_demux_done      = r.demux;
  assign aligned              = r.aligned;
  assign aligned_error        = r.aligned_err;
  assign misaligned           = r.misaligned;
  assign pcs_status           = r.status;
  assign local_fault          = r.local_f;
  assign remote_fault         = r.remote;
  assign high_error_rate      = r.hi_ber;
  assign irq                  = r.irq;
  assign prdata               = r.prdata;
  assign pready               = r.pready;
  assign pslverr              = r.pslverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_word_err_pulse: assert property ( // R03
    marker_word_error == $past(marker_malformed))
    else $error("marker word error did not follow malformed marker");
  a_repeat_after_four: assert property ( // R02
    marker_repeat_error[1] |-> r.consec[1] == repeat_limit)
    else $error("repeat error without four consecutive errors");
  a_aligned_level: assert property ( // R04
    aligned |-> (&lane_demux_done) && (&block_lock))
    else $error("aligned while a lane is not demuxed or locked");
  // local fault first rises at the first edge after reset is released
  a_local_fault: assert property ( // R05
    (aligned || $past(presetn)) |-> local_fault == !aligned)
    else $error("local fault does not mirror aligned");
  a_status_and: assert property ( // R06
    pcs_status == (aligned && !high_error_rate))
    else $error("pcs status not aligned and not high error rate");
  a_align_lost: assert property ( // R08
    $fell(aligned) |-> aligned_error)
    else $error("alignment loss not flagged");
  a_mis_gated: assert property ( // R18
    !(&r.seen_ok) |=> !r.mf_pend && !misaligned)
    else $error("misaligned before all lanes saw markers");
  a_mis_delay: assert property ( // R10
    ($rose(r.mf_pend) && r.mf_cnt == 16'h0007 && word_valid[0])
    ##1 word_valid[0] [*6] |=> ##1 misaligned)
    else $error("misaligned pulse not one metaframe late");
  a_sync_marker: assert property ( // R14
    word_synced[0] |-> r.got_marker[0])
    else $error("sync bit without a received marker");
  a_irq_level: assert property (
    irq |-> |(r.irq_stat & r.irq_mask))
    else $error("interrupt high without unmasked cause");

  c_aligned: cover property ($rose(aligned));
  c_misaligned: cover property (misaligned);
  c_repeat: cover property ($rose(|marker_repeat_error));
  c_irq: cover property ($rose(irq));

endmodule : rx_lane_alignment_status
